// File: logic/dram_bank_config_decode.sv
// dram bank configuration registers, bank decode and strobe sequencing
// assumes synchronous i/o port and memory requests from the system side
`timescale 1ns/1ps
`default_nettype none
`include "dbcd_params.svh"

module dram_bank_config_decode
#(
  parameter int PIO_CYCLES = `DBCD_PIO_CYC
)
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // i/o port register access
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [15:0] i_io_wdata,
  output logic      [15:0] o_io_rdata,
  // memory access request
  input  wire logic        i_mem_req,
  input  wire logic [24:0] i_mem_addr,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_protect,
  input  wire logic        i_mem_write_strobe,
  output logic             o_mem_done,
  output logic             o_mem_abort,
  // peripheral i/o cycle request
  input  wire logic        i_pio_req,
  input  wire logic [3:0]  i_pio_cs_code,
  input  wire logic        i_pio_wr,
  input  wire logic [7:0]  i_pio_wdata,
  output logic      [7:0]  o_pio_rdata,
  output logic             o_pio_done,
  // shared pin and hold acknowledge
  input  wire logic        i_cache_mode_pin,
  input  wire logic        i_hold_ack,
  output logic             o_alt_clock,
  output logic             o_parity_err,
  output logic      [1:0]  o_cache_mode_active,
  // dram side
  input  wire logic [10:0] i_mem_addr_bus,
  output logic      [10:0] o_mem_addr_bus,
  output logic             o_addr_hi_oe_n,
  output logic             o_addr_lo_oe_n,
  output logic             o_chip_sel_code_msb,
  output logic      [3:0]  o_ras_n,
  output logic             o_cas_n,
  output logic             o_cas_tail
);

  generate
    if (PIO_CYCLES < 1 || PIO_CYCLES > 7)
    begin : g_bad_pio
      $error("PIO_CYCLES must lie in 1..7");
    end
  endgenerate

  localparam logic [2:0] PIO_LAST = 3'(PIO_CYCLES - 1);

  localparam dbcd_pkg::dbcd_state_s ST_RST = '{
    fsm:     dbcd_pkg::ST_IDLE,
    ctrl:    dbcd_pkg::dbcd_ctrl_s'(`DBCD_CTRL_RST),
    ras_n:   4'hF,
    cas_n:   1'b1,
    hi_oe_n: 1'b1,
    lo_oe_n: 1'b1,
    default: '0
  };

  dbcd_pkg::dbcd_state_s st_reg;
  dbcd_pkg::dbcd_state_s st_next;

  // interleave factor of a bank, as a power of two
  function automatic logic [1:0] dbcd_ilv_log2(input logic [2:0] interleave_sel, input int idx);
    logic [1:0] r;
    r = 2'h0;
    unique case (interleave_sel)
      `DBCD_ILV_PAIR01: r = (idx < 2) ? 2'h1 : 2'h0;
      `DBCD_ILV_PAIR23: r = (idx >= 2) ? 2'h1 : 2'h0;
      `DBCD_ILV_BOTH:   r = 2'h1;
      `DBCD_ILV_FOUR:   r = 2'h2;
      default:          r = 2'h0;
    endcase
    return r;
  endfunction

  // address bits that pick the member of an interleaved group
  function automatic logic [1:0] dbcd_member(input logic [24:0] a, input logic [1:0] sz,
                                             input logic pg);
    logic [24:0] s;
    // word interleave splits on word bit, page interleave above the page
    s = pg ? (a >> (`DBCD_PAGE_ILV_BIT + int'(sz))) : (a >> `DBCD_WORD_ILV_BIT);
    return s[1:0];
  endfunction

  // row or column of a word address for a by-16 device
  function automatic logic [10:0] dbcd_mux_addr(input logic [24:0] a, input logic [1:0] sz,
                                                input logic [1:0] lg, input logic pg,
                                                input logic row);
    logic [23:0] w;
    logic [23:0] s;
    int          n;
    int          sh;
    w = a[24:1];
    n = `DBCD_COL_BITS_MIN + int'(sz);
    if (pg)
      sh = row ? n + int'(lg) : 0;
    else
      sh = row ? n + int'(lg) : int'(lg);
    s = w >> sh;
    return s[10:0] & 11'((32'd1 << n) - 32'd1);
  endfunction

  // one-hot of the lowest set bit
  function automatic logic [3:0] dbcd_first(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction

  logic [3:0]  bank_hit;
  logic [3:0]  bank_ok;
  logic [1:0]  bank_lg [4];
  logic [7:0]  bank_base [4];
  logic        dis_region;
  logic [24:0] dis_limit;
  logic        cache_hit;
  logic [1:0]  sel_size;
  logic [1:0]  sel_lg;
  logic        wr_block;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bank
      logic [1:0] member;
      assign bank_lg[gi]   = dbcd_ilv_log2(st_reg.ctrl.interleave_sel, gi);
      assign bank_base[gi] = (gi < 2) ? st_reg.start_a[gi*`DBCD_BASE_W +: `DBCD_BASE_W]
                                      : st_reg.start_b[(gi-2)*`DBCD_BASE_W +: `DBCD_BASE_W];
      assign member = dbcd_member(i_mem_addr, st_reg.ctrl.size[gi*`DBCD_SIZE_W +: `DBCD_SIZE_W],
                                  st_reg.ctrl.page_mode);
      dbcd_bank_match u_match
      (
        .i_size     (st_reg.ctrl.size[gi*`DBCD_SIZE_W +: `DBCD_SIZE_W]),
        .i_ilv_log2 (bank_lg[gi]),
        .i_base     (bank_base[gi]),
        .i_enable   (st_reg.bank_en[gi]),
        .i_addr     (i_mem_addr),
        .o_hit      (bank_hit[gi])
      );
      // only the group member addressed by the interleave bits may answer
      assign bank_ok[gi] = bank_hit[gi] && !dis_region &&
                           ((bank_lg[gi] == 2'h0) ||
                            (bank_lg[gi] == 2'h1 && member[0] == 1'(gi % 2)) ||
                            (bank_lg[gi] == 2'h2 && member == 2'(gi)));
    end
  endgenerate

  always_comb
  begin
    unique case (st_reg.mem_dis)
      `DBCD_DIS_512: dis_limit = `DBCD_LIM_512K;
      `DBCD_DIS_256: dis_limit = `DBCD_LIM_256K;
      `DBCD_DIS_128: dis_limit = `DBCD_LIM_128K;
      default:       dis_limit = `DBCD_TOP_640K;
    endcase
    dis_region = (i_mem_addr >= dis_limit) && (i_mem_addr < `DBCD_TOP_640K);
  end

  // geometry of the bank latched for the current access
  always_comb
  begin
    sel_size = 2'h0;
    sel_lg   = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (st_reg.bank_sel[i])
      begin
        sel_size = st_reg.ctrl.size[i*`DBCD_SIZE_W +: `DBCD_SIZE_W];
        sel_lg   = bank_lg[i];
      end
    end
  end

  assign cache_hit = (st_reg.cm_active == `DBCD_CM_CACHE) && i_cache_mode_pin;
  assign wr_block  = !st_reg.is_rd && st_reg.prot && i_mem_write_strobe;

  always_comb
  begin
    st_next           = st_reg;
    st_next.mem_done  = 1'b0;
    st_next.mem_abort = 1'b0;
    st_next.pio_done  = 1'b0;

    // shared pin meaning follows the mode now in effect
    st_next.alt_clk = (st_reg.cm_active == `DBCD_CM_NONE) && i_cache_mode_pin;
    st_next.par_err = (st_reg.cm_active == `DBCD_CM_EXTMC) && i_cache_mode_pin;

    // pin function swaps only when the bus is surrendered
    if (i_hold_ack)
      st_next.cm_active = st_reg.ctrl.cache_mode;

    if (i_io_wr)
    begin
      unique case (i_io_addr)
        `DBCD_OFS_CTRL:
        begin
          st_next.ctrl      = dbcd_pkg::dbcd_ctrl_s'(i_io_wdata);
          st_next.ctrl.rsvd = 1'b0;
        end
        `DBCD_OFS_START_A: st_next.start_a = i_io_wdata;
        `DBCD_OFS_START_B: st_next.start_b = i_io_wdata;
        `DBCD_OFS_ENABLE:  st_next.bank_en = i_io_wdata[`DBCD_EN_LSB +: 4];
        `DBCD_OFS_DISABLE: st_next.mem_dis = i_io_wdata[`DBCD_DIS_LSB +: 2];
        default: ;
      endcase
    end

    if (i_io_rd)
    begin
      unique case (i_io_addr)
        `DBCD_OFS_CTRL:    st_next.io_rdata = 16'(st_reg.ctrl);
        `DBCD_OFS_START_A: st_next.io_rdata = st_reg.start_a;
        `DBCD_OFS_START_B: st_next.io_rdata = st_reg.start_b;
        `DBCD_OFS_ENABLE:  st_next.io_rdata = 16'(st_reg.bank_en) << `DBCD_EN_LSB;
        `DBCD_OFS_DISABLE: st_next.io_rdata = 16'(st_reg.mem_dis) << `DBCD_DIS_LSB;
        default:           st_next.io_rdata = 16'h0000;
      endcase
    end

    unique case (st_reg.fsm)
      dbcd_pkg::ST_IDLE:
      begin
        if (i_pio_req)
        begin
          st_next.fsm        = dbcd_pkg::ST_PIO;
          st_next.cnt        = PIO_LAST;
          st_next.pio_wr     = i_pio_wr;
          st_next.bus[10:8]  = i_pio_cs_code[2:0];
          st_next.cs_msb     = i_pio_cs_code[3];
          st_next.hi_oe_n    = 1'b0;
          st_next.bus[7:0]   = i_pio_wdata;
          st_next.lo_oe_n    = !i_pio_wr;
        end
        else if (i_mem_req)
        begin
          st_next.addr     = i_mem_addr;
          st_next.is_rd    = i_mem_rd;
          st_next.prot     = i_mem_protect;
          st_next.bank_sel = dbcd_first(bank_ok);
          if (bank_ok == 4'h0)
            st_next.mem_done = 1'b1;
          else if (i_mem_rd && st_reg.cm_active == `DBCD_CM_CACHE)
            st_next.fsm = dbcd_pkg::ST_CWAIT;
          else
            st_next.fsm = dbcd_pkg::ST_ROW;
        end
      end

      dbcd_pkg::ST_CWAIT:
        st_next.fsm = dbcd_pkg::ST_ROW;

      dbcd_pkg::ST_ROW:
      begin
        // row address with its strobe on the one matching bank
        st_next.fsm     = dbcd_pkg::ST_COL;
        st_next.cnt     = `DBCD_CAS_CYC;
        st_next.bus     = dbcd_mux_addr(st_reg.addr, sel_size, sel_lg,
                                        st_reg.ctrl.page_mode, 1'b1);
        st_next.hi_oe_n = 1'b0;
        st_next.lo_oe_n = 1'b0;
        st_next.ras_n   = ~st_reg.bank_sel;
      end

      dbcd_pkg::ST_COL:
      begin
        st_next.bus   = dbcd_mux_addr(st_reg.addr, sel_size, sel_lg,
                                      st_reg.ctrl.page_mode, 1'b0);
        // protected write withholds the strobe but still ends, so no stall
        st_next.cas_n = wr_block;
        st_next.cnt   = st_reg.cnt - 3'h1;
        if (st_reg.cnt == 3'h0)
        begin
          st_next.fsm      = dbcd_pkg::ST_PRE;
          st_next.cas_n    = 1'b1;
          st_next.ras_n    = 4'hF;
          // half-clock extension of the read strobe, gated outside by the clock
          st_next.cas_tail = st_reg.is_rd && !st_reg.ctrl.cas_narrow;
          st_next.mem_done = 1'b1;
          st_next.cnt      = 3'h0;
        end
      end

      dbcd_pkg::ST_PRE:
      begin
        st_next.fsm      = dbcd_pkg::ST_IDLE;
        st_next.cas_tail = 1'b0;
        st_next.hi_oe_n  = 1'b1;
        st_next.lo_oe_n  = 1'b1;
      end

      dbcd_pkg::ST_PIO:
      begin
        st_next.cnt = st_reg.cnt - 3'h1;
        if (st_reg.cnt == 3'h0)
        begin
          st_next.fsm       = dbcd_pkg::ST_IDLE;
          st_next.pio_rdata = st_reg.pio_wr ? st_reg.pio_rdata : i_mem_addr_bus[7:0];
          st_next.pio_done  = 1'b1;
          st_next.hi_oe_n   = 1'b1;
          st_next.lo_oe_n   = 1'b1;
          st_next.cs_msb    = 1'b0;
          st_next.cnt       = 3'h0;
        end
      end
    endcase

    // a cache hit kills any read still in flight
    if (cache_hit && st_reg.is_rd &&
        (st_reg.fsm == dbcd_pkg::ST_CWAIT || st_reg.fsm == dbcd_pkg::ST_ROW ||
         st_reg.fsm == dbcd_pkg::ST_COL))
    begin
      st_next.fsm       = dbcd_pkg::ST_PRE;
      st_next.ras_n     = 4'hF;
      st_next.cas_n     = 1'b1;
      st_next.cas_tail  = 1'b0;
      st_next.mem_done  = 1'b1;
      st_next.mem_abort = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  assign o_io_rdata          = st_reg.io_rdata;
  assign o_mem_done          = st_reg.mem_done;
  assign o_mem_abort         = st_reg.mem_abort;
  assign o_pio_rdata         = st_reg.pio_rdata;
  assign o_pio_done          = st_reg.pio_done;
  assign o_alt_clock         = st_reg.alt_clk;
  assign o_parity_err        = st_reg.par_err;
  assign o_cache_mode_active = st_reg.cm_active;
  assign o_mem_addr_bus      = st_reg.bus;
  assign o_addr_hi_oe_n      = st_reg.hi_oe_n;
  assign o_addr_lo_oe_n      = st_reg.lo_oe_n;
  assign o_chip_sel_code_msb = st_reg.cs_msb;
  assign o_ras_n             = st_reg.ras_n;
  assign o_cas_n             = st_reg.cas_n;
  assign o_cas_tail          = st_reg.cas_tail;

endmodule
`default_nettype wire

// File: logic/dbcd_params.svh
// constants for the dram bank configuration and decode block
// assumes 16-bit i/o port registers and a 25-bit physical memory address
//
// Operation
// - row then column on address bus
// - top three address lines carry select code
// - low eight address lines carry data
// - protected write withholds column strobe
// - on-board memory disable below 640K
// - read strobe 2.5 or 2 clocks
// - cache mode adds one read wait
// - cache hit aborts the dram read
// - cache mode selects shared pin function
// - cache mode changes at hold acknowledge
// - page bit picks word or page interleave
// - interleave field selects bank pairing
// - size field picks by-16 device organisation
// - start registers hold A24..A17 per bank
// - interleave doubles or quadruples bank size
// - bank and page size follow size field
// - disabled bank never selected
// - disable field picks disabled region
`ifndef DBCD_PARAMS_SVH
`define DBCD_PARAMS_SVH

// i/o port offsets
`define DBCD_OFS_CTRL     16'h3872
`define DBCD_OFS_START_A  16'h4872
`define DBCD_OFS_START_B  16'h5072
`define DBCD_OFS_ENABLE   16'h5872
`define DBCD_OFS_DISABLE  16'h6072

// reset values and field positions
`define DBCD_CTRL_RST     16'h0000
`define DBCD_EN_LSB       12
`define DBCD_DIS_LSB      14
`define DBCD_SIZE_W       2
`define DBCD_BASE_W       8

// interleave codes
`define DBCD_ILV_PAIR01   3'h1
`define DBCD_ILV_PAIR23   3'h2
`define DBCD_ILV_BOTH     3'h3
`define DBCD_ILV_FOUR     3'h4

// cache mode codes
`define DBCD_CM_NONE      2'h0
`define DBCD_CM_CACHE     2'h1
`define DBCD_CM_EXTMC     2'h2

// on-board disable codes
`define DBCD_DIS_512      2'h1
`define DBCD_DIS_256      2'h2
`define DBCD_DIS_128      2'h3

// address geometry
`define DBCD_BANK_LSB     17
`define DBCD_WORD_ILV_BIT 1
`define DBCD_PAGE_ILV_BIT 9
`define DBCD_COL_BITS_MIN 8
`define DBCD_TOP_640K     25'h00A0000
`define DBCD_LIM_512K     25'h0080000
`define DBCD_LIM_256K     25'h0040000
`define DBCD_LIM_128K     25'h0020000

// timing in processor clocks
`define DBCD_CAS_CYC      3'h2
`define DBCD_PIO_CYC      4

`endif

// File: logic/dbcd_pkg.sv
// types for the dram bank configuration and decode block
// assumes dbcd_params.svh supplies the numeric constants
package dbcd_pkg;

  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'h01,
    ST_CWAIT = 6'h02,
    ST_ROW   = 6'h04,
    ST_COL   = 6'h08,
    ST_PRE   = 6'h10,
    ST_PIO   = 6'h20
  } dbcd_fsm_e;

  // layout of the control register, msb first
  typedef struct packed {
    logic       cas_narrow;
    logic       rsvd;
    logic [1:0] cache_mode;
    logic       page_mode;
    logic [2:0] interleave_sel;
    logic [7:0] size;
  } dbcd_ctrl_s;

  typedef struct packed {
    dbcd_fsm_e   fsm;
    dbcd_ctrl_s  ctrl;
    logic [1:0]  cm_active;
    logic [15:0] start_a;
    logic [15:0] start_b;
    logic [3:0]  bank_en;
    logic [1:0]  mem_dis;
    logic [24:0] addr;
    logic        is_rd;
    logic        prot;
    logic [3:0]  bank_sel;
    logic [2:0]  cnt;
    logic        pio_wr;
    logic [3:0]  ras_n;
    logic        cas_n;
    logic        cas_tail;
    logic [10:0] bus;
    logic        hi_oe_n;
    logic        lo_oe_n;
    logic        cs_msb;
    logic        mem_done;
    logic        mem_abort;
    logic [15:0] io_rdata;
    logic [7:0]  pio_rdata;
    logic        pio_done;
    logic        alt_clk;
    logic        par_err;
  } dbcd_state_s;

endpackage

// File: logic/dbcd_bank_match.sv
// address match of one dram bank against its base and effective size
// assumes base holds A24..A17 and size is aligned by software
`timescale 1ns/1ps
`default_nettype none
`include "dbcd_params.svh"

module dbcd_bank_match
(
  // bank configuration
  input  wire logic [1:0]  i_size,
  input  wire logic [1:0]  i_ilv_log2,
  input  wire logic [7:0]  i_base,
  input  wire logic        i_enable,
  // access address
  input  wire logic [24:0] i_addr,
  // result
  output logic             o_hit
);

  logic [3:0] span;
  logic [7:0] mask;

  always_comb
  begin
    // 128K bank grows by 4x per size step, 2x per interleave step
    span  = {1'b0, i_size, 1'b0} + {2'b00, i_ilv_log2};
    mask  = 8'hFF << span;
    o_hit = i_enable && (((i_addr[24:`DBCD_BANK_LSB] ^ i_base) & mask) == 8'h00);
  end

endmodule
`default_nettype wire

// File: bench/dbcd_chk.sv
// concurrent checks on the dram bank decode block ports
// assumes binding to the block top, one clock, reset active high
`timescale 1ns/1ps
`default_nettype none

module dbcd_chk
#(
  parameter int PIO_CYCLES = 4
)
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // stimulus
  input wire logic        i_pio_req,
  input wire logic [3:0]  i_pio_cs_code,
  input wire logic        i_cache_mode_pin,
  input wire logic        i_hold_ack,
  // responses
  input wire logic        o_mem_done,
  input wire logic        o_mem_abort,
  input wire logic        o_pio_done,
  input wire logic        o_alt_clock,
  input wire logic        o_parity_err,
  input wire logic [1:0]  o_cache_mode_active,
  input wire logic [10:0] o_mem_addr_bus,
  input wire logic        o_addr_hi_oe_n,
  input wire logic        o_addr_lo_oe_n,
  input wire logic        o_chip_sel_code_msb,
  input wire logic [3:0]  o_ras_n,
  input wire logic        o_cas_n,
  input wire logic        o_cas_tail
);
  localparam int PD = PIO_CYCLES + 1;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  chk_one_row: assert property ($onehot0(~o_ras_n))
    else $error("two row strobes low");
  chk_col_in_row: assert property (!o_cas_n |-> o_ras_n != 4'hF && !o_addr_lo_oe_n)
    else $error("column strobe outside row");
  chk_col_width: assert property ($fell(o_cas_n) |=> !o_cas_n ##1 o_cas_n)
    else $error("column strobe width");
  chk_tail_edge: assert property (o_cas_tail |-> o_cas_n && !$past(o_cas_n))
    else $error("tail flag misplaced");
  chk_hit_abort: assert property (o_mem_abort |-> o_mem_done &&
    $past(o_cache_mode_active) == 2'h1 && $past(i_cache_mode_pin)) else $error("abort no hit");
  chk_alt_clock: assert property (o_alt_clock |->
    $past(o_cache_mode_active) == 2'h0 && $past(i_cache_mode_pin)) else $error("alt clock wrong");
  chk_parity_pin: assert property (o_parity_err |->
    $past(o_cache_mode_active) == 2'h2 && $past(i_cache_mode_pin)) else $error("parity wrong");
  chk_mode_hold: assert property (!$stable(o_cache_mode_active) |-> $past(i_hold_ack))
    else $error("mode changed without hold");
  chk_pio_code: assert property (i_pio_req |=> !o_addr_hi_oe_n &&
    {o_chip_sel_code_msb, o_mem_addr_bus[10:8]} == $past(i_pio_cs_code)) else $error("code");
  chk_pio_done: assert property (i_pio_req |-> ##PD o_pio_done)
    else $error("peripheral cycle length");
  cover property (o_pio_done);
  cover property (o_mem_abort);
  cover property (o_cas_tail);
endmodule

bind dram_bank_config_decode dbcd_chk #(.PIO_CYCLES(PIO_CYCLES)) dbcd_chk_i
(
  .i_clk, .i_sys_rst, .i_pio_req, .i_pio_cs_code, .i_cache_mode_pin, .i_hold_ack,
  .o_mem_done, .o_mem_abort, .o_pio_done, .o_alt_clock, .o_parity_err,
  .o_cache_mode_active, .o_mem_addr_bus, .o_addr_hi_oe_n, .o_addr_lo_oe_n,
  .o_chip_sel_code_msb, .o_ras_n, .o_cas_n, .o_cas_tail
);
`default_nettype wire

// File: bench/dbcd_far_side.sv
// far side of the shared address bus: line keeper and one peripheral
// assumes active-low enables; released lines show the inverse of the last level
`timescale 1ns/1ps
`default_nettype none

module dbcd_far_side
#(
  parameter logic [7:0] RD_DATA = 8'hA5
)
(
  // bus half driven by the block
  input  wire logic        i_clk,
  input  wire logic [10:0] i_drv,
  input  wire logic        i_hi_oe_n,
  input  wire logic        i_lo_oe_n,
  // resolved wire level
  output logic      [10:0] o_wire
);
  logic [10:0] last_reg;
  // peripheral answers only a selected read, low byte released by the block
  assign o_wire[10:8] = i_hi_oe_n ? ~last_reg[10:8] : i_drv[10:8];
  assign o_wire[7:0] = !i_lo_oe_n ? i_drv[7:0] : (!i_hi_oe_n ? RD_DATA : ~last_reg[7:0]);
  // remember only driven levels, so a released line stays put
  always_ff @(posedge i_clk)
  begin
    if (!i_hi_oe_n)
      last_reg[10:8] <= i_drv[10:8];
    if (!i_lo_oe_n)
      last_reg[7:0] <= i_drv[7:0];
  end
endmodule
`default_nettype wire

// File: bench/tb_dram_bank_config_decode.sv
// self-checking bench for the dram bank decode block
// assumes the far-side bus model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_dram_bank_config_decode;
  localparam int PIO = 3;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_io_wr = 1'b0, i_io_rd = 1'b0;
  logic [15:0] i_io_addr = '0, i_io_wdata = '0, o_io_rdata;
  logic        i_mem_req = 1'b0, i_mem_rd = 1'b0, i_mem_protect = 1'b0;
  logic        i_mem_write_strobe = 1'b0, i_pio_req = 1'b0, i_pio_wr = 1'b0;
  logic        i_cache_mode_pin = 1'b0, i_hold_ack = 1'b0;
  logic [24:0] i_mem_addr = '0;
  logic [3:0]  i_pio_cs_code = '0, o_ras_n, ras_seen;
  logic [7:0]  i_pio_wdata = '0, o_pio_rdata;
  logic [10:0] i_mem_addr_bus, o_mem_addr_bus, row_seen, col_seen;
  logic [1:0]  o_cache_mode_active;
  logic        o_mem_done, o_mem_abort, o_pio_done, o_alt_clock, o_parity_err, o_cas_n;
  logic        o_addr_hi_oe_n, o_addr_lo_oe_n, o_chip_sel_code_msb, o_cas_tail;
  logic        cas_seen, tail_seen, abort_seen;
  int          ncyc, err_total = 0, n_checks = 0;
  logic [24:0] dec_a [9] = '{25'h0000000, 25'h07FFFFE, 25'h0800000, 25'h09FFFFE,
                             25'h0A00000, 25'h0A7FFFE, 25'h0A80000, 25'h0A9FFFE, 25'h0AA0000};
  logic [3:0]  dec_r [9] = '{4'h7, 4'h7, 4'hB, 4'hB, 4'hE, 4'hE, 4'hD, 4'hD, 4'hF};
  logic [15:0] ilv_c [10] = '{16'h0155, 16'h0155, 16'h0955, 16'h0955, 16'h0255,
                              16'h0255, 16'h0355, 16'h0355, 16'h0C55, 16'h0C55};
  logic [24:0] ilv_a [10] = '{25'h0A80000, 25'h0A80002, 25'h0A00400, 25'h0A00002, 25'h0800002,
                              25'h0880000, 25'h0A00002, 25'h0800002, 25'h0A00800, 25'h0BFFE00};
  logic [3:0]  ilv_r [10] = '{4'hE, 4'hD, 4'hD, 4'hE, 4'h7, 4'hB, 4'hD, 4'h7, 4'hB, 4'h7};
  logic [1:0]  cm [3] = '{2'h2, 2'h0, 2'h1};

  always #12.5 i_clk = ~i_clk;

  dram_bank_config_decode #(.PIO_CYCLES(PIO)) dram_bank_config_decode_i
  (
    .i_clk, .i_sys_rst, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata,
    .i_mem_req, .i_mem_addr, .i_mem_rd, .i_mem_protect, .i_mem_write_strobe,
    .o_mem_done, .o_mem_abort, .i_pio_req, .i_pio_cs_code, .i_pio_wr, .i_pio_wdata,
    .o_pio_rdata, .o_pio_done, .i_cache_mode_pin, .i_hold_ack, .o_alt_clock,
    .o_parity_err, .o_cache_mode_active, .i_mem_addr_bus, .o_mem_addr_bus,
    .o_addr_hi_oe_n, .o_addr_lo_oe_n, .o_chip_sel_code_msb, .o_ras_n, .o_cas_n, .o_cas_tail
  );
  dbcd_far_side dbcd_far_side_i
  (
    .i_clk, .i_drv(o_mem_addr_bus), .i_hi_oe_n(o_addr_hi_oe_n),
    .i_lo_oe_n(o_addr_lo_oe_n), .o_wire(i_mem_addr_bus)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one port access; a read compares the returned word
  task automatic io(input logic rd, input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_io_addr = a;
    i_io_wdata = d;
    {i_io_rd, i_io_wr} = {rd, !rd};
    @(negedge i_clk);
    {i_io_rd, i_io_wr} = 2'b00;
    if (rd)
      check(o_io_rdata, d);
  endtask

  task automatic mem(input logic [24:0] a, input logic rd, input logic pr);
    int k;
    @(negedge i_clk);
    {i_mem_addr, i_mem_rd, i_mem_protect, i_mem_req} = {a, rd, pr, 1'b1};
    @(negedge i_clk);
    i_mem_req = 1'b0;
    {ras_seen, cas_seen, ncyc} = {4'hF, 1'b0, 32'd1};
    for (k = 0; k < 20 && o_mem_done !== 1'b1; k++)
    begin
      if (ras_seen == 4'hF && o_ras_n != 4'hF)
        row_seen = o_mem_addr_bus;
      if (!o_cas_n)
        col_seen = o_mem_addr_bus;
      ras_seen &= o_ras_n;
      cas_seen |= !o_cas_n;
      @(negedge i_clk);
      ncyc++;
    end
    if (k == 20)
    begin
      err_total++;
      stop_test();
    end
    {tail_seen, abort_seen} = {o_cas_tail, o_mem_abort};
    @(negedge i_clk);
    tail_seen |= o_cas_tail;
  endtask

  // unhit reads finish at once, hits take five cycles
  task automatic dec(input logic [24:0] a, input logic [3:0] exp);
    mem(a, 1'b1, 1'b0);
    check(ras_seen, exp);
    check(ncyc, exp == 4'hF ? 1 : 5);
  endtask

  task automatic pio(input logic [3:0] c, input logic wr);
    int k;
    @(negedge i_clk);
    {i_pio_cs_code, i_pio_wr, i_pio_wdata, i_pio_req} = {c, wr, 4'h3, c, 1'b1};
    @(negedge i_clk);
    i_pio_req = 1'b0;
    check({o_chip_sel_code_msb, o_mem_addr_bus[10:8], o_addr_hi_oe_n}, {c, 1'b0});
    if (wr)
      check({o_mem_addr_bus[7:0], o_addr_lo_oe_n}, {4'h3, c, 1'b0});
    for (k = 1; k < 20 && o_pio_done !== 1'b1; k++)
      @(negedge i_clk);
    if (k == 20)
    begin
      err_total++;
      stop_test();
    end
    check(k, PIO + 1);
    @(negedge i_clk);
    if (!wr)
      check(o_pio_rdata, 8'hA5);
  endtask

  initial
  begin
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    io(1'b1, 16'h5872, 16'h0000);
    io(1'b1, 16'h6072, 16'h0000);
    dec(25'h0000000, 4'hF);
    io(1'b0, 16'h3872, 16'hFFFF);
    io(1'b1, 16'h3872, 16'hBFFF);
    io(1'b1, 16'h1234, 16'h0000);
    i_sys_rst = 1'b1;
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    io(1'b1, 16'h3872, 16'h0000);
    io(1'b0, 16'h5872, 16'hFFFF);
    io(1'b1, 16'h5872, 16'hF000);
    io(1'b0, 16'h6072, 16'hFFFF);
    io(1'b1, 16'h6072, 16'hC000);
    io(1'b0, 16'h6072, 16'h0000);
    // 8M, 2M, 128K, 512K from bank 3 down, smaller banks higher
    io(1'b0, 16'h3872, 16'h00E1);
    io(1'b0, 16'h4872, 16'h5450);
    io(1'b1, 16'h4872, 16'h5450);
    io(1'b0, 16'h5072, 16'h0040);
    io(1'b1, 16'h5072, 16'h0040);
    foreach (dec_a[i])
      dec(dec_a[i], dec_r[i]);
    io(1'b0, 16'h5872, 16'hE000);
    dec(25'h0A00000, 4'hF);
    io(1'b0, 16'h5872, 16'hF000);
    for (int d = 1; d < 4; d++)
    begin
      io(1'b0, 16'h6072, {d[1:0], 14'h0000});
      dec(25'h0100000 >> d, 4'hF);
      dec((25'h0100000 >> d) - 25'h0000002, 4'h7);
      dec(25'h009FFFE, 4'hF);
      dec(25'h00A0000, 4'h7);
    end
    io(1'b0, 16'h6072, 16'h0000);
    io(1'b0, 16'h4872, 16'h5050);
    io(1'b0, 16'h5072, 16'h4040);
    foreach (ilv_c[i])
    begin
      if (ilv_c[i] == 16'h0C55)
        io(1'b0, 16'h5072, 16'h5050);
      io(1'b0, 16'h3872, ilv_c[i]);
      dec(ilv_a[i], ilv_r[i]);
    end
    foreach (cm[i])
    begin
      io(1'b0, 16'h3872, {2'b00, cm[i], 12'hC55});
      i_cache_mode_pin = 1'b1;
      @(negedge i_clk);
      check(o_cache_mode_active, i == 0 ? 2'h0 : cm[i - 1]);
      i_hold_ack = 1'b1;
      @(negedge i_clk);
      i_hold_ack = 1'b0;
      @(negedge i_clk);
      check(o_cache_mode_active, cm[i]);
      check({o_alt_clock, o_parity_err}, {cm[i] == 2'h0, cm[i] == 2'h2});
    end
    i_cache_mode_pin = 1'b0;
    mem(25'h0A00400, 1'b1, 1'b0);
    check({ncyc[30:0], tail_seen}, {31'd6, 1'b1});
    mem(25'h0A00400, 1'b0, 1'b0);
    check({ncyc[30:0], tail_seen}, {31'd5, 1'b0});
    io(1'b0, 16'h3872, 16'h9C55);
    mem(25'h0A00400, 1'b1, 1'b0);
    check({cas_seen, tail_seen}, 2'b10);
    i_cache_mode_pin = 1'b1;
    mem(25'h0A00400, 1'b1, 1'b0);
    check(abort_seen, 1'b1);
    {i_cache_mode_pin, i_mem_write_strobe} = 2'b01;
    mem(25'h0A00400, 1'b0, 1'b1);
    check({ras_seen, cas_seen}, {4'hD, 1'b0});
    mem(25'h0A00400, 1'b0, 1'b0);
    check(cas_seen, 1'b1);
    mem(25'h0A0F40A, 1'b0, 1'b0);
    check({row_seen, col_seen}, {11'h00F, 11'h005});
    i_mem_write_strobe = 1'b0;
    for (int c = 0; c < 16; c++)
      pio(c[3:0], c[0]);
    stop_test();
  end
endmodule
`default_nettype wire
